//--- logic/capture_pkg.sv
/*
  constants for the two-group capture control block: register offsets,
  field positions inside each channel byte, reset values.
  assumes a 9-bit byte address with the top bit choosing the group.

// Overview of operation
// - falling edge on channel 3 stores counter in fall latch, sets bit 23
// - rising edge on channel 3 stores counter in rise latch, sets bit 22
// - latched indicators clear when written value equals clear polarity select
// - rise irq enable bit 17 lets a rising edge set flag bit 20
// - fall irq enable bit 18 lets a falling edge set flag bit 20
// - capture irq flag clears only on write of 1, zero leaves it
// - capture enable bit 19 high lets edges update both latch registers
// - capture enable low blocks latch updates and the capture interrupt
// - control register at offset 0x54, resets zero, ch3 bits 23..16, ch2 7..0
// - two independent copies, group A and group B, each at own base
// - inverter bit high inverts pin before edge detection, low passes through
// - channel 2 mirrors channel 3 in bits 7..0 with same field order
*/
package capture_pkg;
    // bus geometry
    localparam int          ADDR_W        = 9;
    localparam int          OFF_W         = 8;
    localparam int          GROUP_SEL_BIT = 8;
    localparam int          DATA_W        = 32;
    localparam int          CHANS         = 2;
    localparam int          FIELD_W       = 8;
    localparam int          CH_STRIDE     = 16;
    localparam int          STAT_W        = 4;

    // group bases
    localparam logic [ADDR_W-1:0] GROUP_A_BASE = 9'h000;
    localparam logic [ADDR_W-1:0] GROUP_B_BASE = 9'h100;

    // register offsets inside a group
    localparam logic [OFF_W-1:0] CTRL_OFF      = 8'h54;
    localparam logic [OFF_W-1:0] RISE_C2_OFF   = 8'h58;
    localparam logic [OFF_W-1:0] FALL_C2_OFF   = 8'h5C;
    localparam logic [OFF_W-1:0] RISE_C3_OFF   = 8'h60;
    localparam logic [OFF_W-1:0] FALL_C3_OFF   = 8'h64;
    localparam logic [OFF_W-1:0] STATUS_OFF    = 8'h68;
    localparam logic [OFF_W-1:0] MASK_OFF      = 8'h6C;

    // field positions inside one channel byte
    localparam int          INV_BIT       = 0;
    localparam int          RISE_IE_BIT   = 1;
    localparam int          FALL_IE_BIT   = 2;
    localparam int          EN_BIT        = 3;
    localparam int          IRQF_BIT      = 4;
    localparam int          RISE_IND_BIT  = 6;
    localparam int          FALL_IND_BIT  = 7;
    localparam int          CFG_W         = 4;

    // reset values
    localparam logic [FIELD_W-1:0] FIELD_RESET = 8'h00;
    localparam logic [STAT_W-1:0]  STAT_RESET  = 4'h0;
    localparam logic [DATA_W-1:0]  RDATA_RESET = 32'h0000_0000;
endpackage

//--- logic/capture_if.sv
/*
  bundle between the control logic and one capture channel.
  assumes both ends share the pwm group clock.
*/
interface capture_if #(
    parameter int CNT_W = 16
);
    logic             pin;
    logic             invert;
    logic             enable;
    logic [CNT_W-1:0] count;
    logic             rise_cap;
    logic             fall_cap;
    logic [CNT_W-1:0] rise_value;
    logic [CNT_W-1:0] fall_value;

    modport ctl  (output pin, output invert, output enable, output count,
                  input rise_cap, input fall_cap, input rise_value, input fall_value);
    modport chan (input pin, input invert, input enable, input count,
                  output rise_cap, output fall_cap, output rise_value, output fall_value);
endinterface

//--- logic/capture_channel.sv
/*
  one capture channel: optional inversion, edge detection and the two
  counter latches. assumes the pin is already synchronous to the clock.
*/
module capture_channel #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // control side
    capture_if.chan   cap
);
    logic             prev_reg;
    logic [CNT_W-1:0] rise_reg;
    logic [CNT_W-1:0] fall_reg;
    logic             level;
    logic             rise_edge;
    logic             fall_edge;

    // toggling the inverter bit can itself look like an edge
    assign level     = cap.pin ^ cap.invert;
    assign rise_edge = level & ~prev_reg;
    assign fall_edge = ~level & prev_reg;

    // edges count only while capture is enabled
    assign cap.rise_cap   = rise_edge & cap.enable;
    assign cap.fall_cap   = fall_edge & cap.enable;
    assign cap.rise_value = rise_reg;
    assign cap.fall_value = fall_reg;

    // edge history keeps running while disabled so enabling sees no stale edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level;
        end
    end

    // counter latches
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rise_reg <= '0;
            fall_reg <= '0;
        end else begin
            if (cap.rise_cap) begin
                rise_reg <= cap.count;
            end
            if (cap.fall_cap) begin
                fall_reg <= cap.count;
            end
        end
    end
endmodule

//--- logic/pwm_capture_top.sv
/*
  capture control for channels 2 and 3 of both pwm groups, with latch
  readback, sticky event status, event mask and interrupt outputs.
  assumes the down counters and capture pins come from the pwm groups
  and are synchronous to REF_CLK_IN; the bus master never overlaps strobes.
*/
module pwm_capture_top #(
    parameter int CNT_W  = 16,
    parameter int GROUPS = 2
) (
    // clock and reset
    input  wire logic                                          REF_CLK_IN,
    input  wire logic                                          NRST_IN,
    // register port
    input  wire logic [capture_pkg::ADDR_W-1:0]                ADDR_IN,
    input  wire logic [capture_pkg::DATA_W-1:0]                WDATA_IN,
    input  wire logic                                          WR_IN,
    input  wire logic                                          RD_IN,
    output logic      [capture_pkg::DATA_W-1:0]                RDATA_OUT,
    // pwm group side
    input  wire logic [GROUPS*capture_pkg::CHANS-1:0]          CAP_PIN_IN,
    input  wire logic [GROUPS*capture_pkg::CHANS*CNT_W-1:0]    CNT_IN,
    input  wire logic [GROUPS-1:0]                             CLR_POL_IN,
    // interrupts
    output logic      [GROUPS-1:0]                             CAP_IRQ_OUT,
    output logic                                               IRQ_OUT
);
    localparam int PAD_W = capture_pkg::DATA_W - CNT_W;
    localparam int MID_W = capture_pkg::CH_STRIDE - capture_pkg::FIELD_W;
    localparam int TOP_W = capture_pkg::DATA_W - capture_pkg::CH_STRIDE
                           - capture_pkg::FIELD_W;

    // address decode shared by both groups
    logic                              grp_sel;
    logic [capture_pkg::OFF_W-1:0]     offset;
    logic                              wr_ctrl_any;
    logic                              wr_mask_any;
    logic                              rd_stat_any;

    assign grp_sel     = ADDR_IN[capture_pkg::GROUP_SEL_BIT];
    assign offset      = ADDR_IN[capture_pkg::OFF_W-1:0];
    assign wr_ctrl_any = WR_IN & (offset == capture_pkg::CTRL_OFF);
    assign wr_mask_any = WR_IN & (offset == capture_pkg::MASK_OFF);
    assign rd_stat_any = RD_IN & (offset == capture_pkg::STATUS_OFF);

    // per-group views gathered for the read mux and the interrupt
    logic [capture_pkg::DATA_W-1:0]    grp_rdata [GROUPS];
    logic [GROUPS-1:0]                 grp_irq;
    logic [GROUPS-1:0]                 grp_cap_irq;

    genvar g;
    genvar c;
    generate
        for (g = 0; g < GROUPS; g++) begin : gen_group
            logic                             hit;
            logic                             wr_ctrl;
            logic                             wr_mask;
            logic                             rd_stat;
            logic [capture_pkg::FIELD_W-1:0]  field [capture_pkg::CHANS];
            logic [CNT_W-1:0]                 rise_val [capture_pkg::CHANS];
            logic [CNT_W-1:0]                 fall_val [capture_pkg::CHANS];
            logic [capture_pkg::CHANS-1:0]    rise_ev;
            logic [capture_pkg::CHANS-1:0]    fall_ev;
            logic [capture_pkg::CHANS-1:0]    irqf;
            logic [capture_pkg::STAT_W-1:0]   stat_reg;
            logic [capture_pkg::STAT_W-1:0]   stat_next;
            logic [capture_pkg::STAT_W-1:0]   stat_set;
            logic [capture_pkg::STAT_W-1:0]   mask_reg;
            logic [capture_pkg::DATA_W-1:0]   ctrl_word;

            // each group answers only at its own base
            assign hit     = (grp_sel == 1'(g));
            assign wr_ctrl = wr_ctrl_any & hit;
            assign wr_mask = wr_mask_any & hit;
            assign rd_stat = rd_stat_any & hit;

            for (c = 0; c < capture_pkg::CHANS; c++) begin : gen_chan
                localparam int K   = g * capture_pkg::CHANS + c;
                localparam int LSB = c * capture_pkg::CH_STRIDE;

                capture_if #(.CNT_W(CNT_W)) link ();

                logic [capture_pkg::FIELD_W-1:0] fld_reg;
                logic [capture_pkg::FIELD_W-1:0] fld_next;
                logic [capture_pkg::FIELD_W-1:0] wd;
                logic                            pol;
                logic                            clr_rise_ind;
                logic                            clr_fall_ind;
                logic                            clr_irqf;
                logic                            set_irqf;

                capture_channel #(
                    .CNT_W    (CNT_W)
                ) u_chan (
                    .clk_in   (REF_CLK_IN),
                    .rst_n_in (NRST_IN),
                    .cap      (link.chan)
                );

                // channel inputs from the pins and the control byte
                assign link.pin    = CAP_PIN_IN[K];
                assign link.count  = CNT_IN[K*CNT_W +: CNT_W];
                assign link.invert = fld_reg[capture_pkg::INV_BIT];
                assign link.enable = fld_reg[capture_pkg::EN_BIT];

                // write decode for this channel's byte
                assign wd  = WDATA_IN[LSB +: capture_pkg::FIELD_W];
                assign pol = CLR_POL_IN[g];
                assign clr_rise_ind = wr_ctrl & (wd[capture_pkg::RISE_IND_BIT] == pol);
                assign clr_fall_ind = wr_ctrl & (wd[capture_pkg::FALL_IND_BIT] == pol);
                assign clr_irqf     = wr_ctrl & wd[capture_pkg::IRQF_BIT];

                // rise_cap and fall_cap are already gated by the enable
                assign set_irqf = (link.rise_cap & fld_reg[capture_pkg::RISE_IE_BIT])
                                | (link.fall_cap & fld_reg[capture_pkg::FALL_IE_BIT]);

                // next value of the byte; a hardware set beats a software clear
                always_comb begin
                    fld_next = fld_reg;
                    if (wr_ctrl) begin
                        fld_next[capture_pkg::CFG_W-1:0] = wd[capture_pkg::CFG_W-1:0];
                    end
                    fld_next[capture_pkg::RISE_IND_BIT] = link.rise_cap
                        | (fld_reg[capture_pkg::RISE_IND_BIT] & ~clr_rise_ind);
                    fld_next[capture_pkg::FALL_IND_BIT] = link.fall_cap
                        | (fld_reg[capture_pkg::FALL_IND_BIT] & ~clr_fall_ind);
                    fld_next[capture_pkg::IRQF_BIT] = set_irqf
                        | (fld_reg[capture_pkg::IRQF_BIT] & ~clr_irqf);
                    fld_next[capture_pkg::IRQF_BIT+1] = 1'b0;    // reserved bit
                end

                // control byte register
                always_ff @(posedge REF_CLK_IN) begin
                    if (!NRST_IN) begin
                        fld_reg <= capture_pkg::FIELD_RESET;
                    end else begin
                        fld_reg <= fld_next;
                    end
                end

                // exports to the group level
                assign field[c]    = fld_reg;
                assign rise_val[c] = link.rise_value;
                assign fall_val[c] = link.fall_value;
                assign rise_ev[c]  = link.rise_cap;
                assign fall_ev[c]  = link.fall_cap;
                assign irqf[c]     = fld_reg[capture_pkg::IRQF_BIT];
            end

            // control word: channel 3 in the upper half, reserved bits zero
            assign ctrl_word = {{TOP_W{1'b0}}, field[1], {MID_W{1'b0}}, field[0]};

            // sticky events: rise2, fall2, rise3, fall3
            assign stat_set  = {fall_ev[1], rise_ev[1], fall_ev[0], rise_ev[0]};
            assign stat_next = stat_set | (stat_reg & ~{capture_pkg::STAT_W{rd_stat}});

            // status clears on read, an event in the read cycle survives
            always_ff @(posedge REF_CLK_IN) begin
                if (!NRST_IN) begin
                    stat_reg <= capture_pkg::STAT_RESET;
                end else begin
                    stat_reg <= stat_next;
                end
            end

            // event mask
            always_ff @(posedge REF_CLK_IN) begin
                if (!NRST_IN) begin
                    mask_reg <= capture_pkg::STAT_RESET;
                end else if (wr_mask) begin
                    mask_reg <= WDATA_IN[capture_pkg::STAT_W-1:0];
                end
            end

            // group read mux; unmapped offsets read as zero
            assign grp_rdata[g] =
                (offset == capture_pkg::CTRL_OFF)    ? ctrl_word :
                (offset == capture_pkg::RISE_C2_OFF) ? {{PAD_W{1'b0}}, rise_val[0]} :
                (offset == capture_pkg::FALL_C2_OFF) ? {{PAD_W{1'b0}}, fall_val[0]} :
                (offset == capture_pkg::RISE_C3_OFF) ? {{PAD_W{1'b0}}, rise_val[1]} :
                (offset == capture_pkg::FALL_C3_OFF) ? {{PAD_W{1'b0}}, fall_val[1]} :
                (offset == capture_pkg::STATUS_OFF)  ?
                    {{(capture_pkg::DATA_W-capture_pkg::STAT_W){1'b0}}, stat_reg} :
                (offset == capture_pkg::MASK_OFF)    ?
                    {{(capture_pkg::DATA_W-capture_pkg::STAT_W){1'b0}}, mask_reg} :
                capture_pkg::RDATA_RESET;

            assign grp_irq[g]     = |(stat_reg & mask_reg);
            assign grp_cap_irq[g] = |irqf;
        end
    endgenerate

    // read data stand only in the cycle after the strobe
    logic [capture_pkg::DATA_W-1:0] rdata_reg;
    logic [capture_pkg::DATA_W-1:0] rdata_next;

    assign rdata_next = RD_IN ? grp_rdata[grp_sel] : capture_pkg::RDATA_RESET;

    always_ff @(posedge REF_CLK_IN) begin
        if (!NRST_IN) begin
            rdata_reg <= capture_pkg::RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // outputs
    assign RDATA_OUT   = rdata_reg;
    assign CAP_IRQ_OUT = grp_cap_irq;
    assign IRQ_OUT     = |grp_irq;
endmodule

//--- tb/capture_pins_model.sv
/*
  far side of the capture block: capture pins and the four down counters.
  assumes the bench commands pin levels; pins change only at a clock edge.
*/
module capture_pins_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // bench command
    input  wire logic [3:0]  pin_cmd_in,
    // pwm group side
    output logic      [3:0]  pin_out,
    output logic      [63:0] cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins follow the command one edge later, counters count down freely
    always_ff @(posedge clk_in) begin
        pin_out <= pin_cmd_in;
        for (int k = 0; k < 4; k++) begin
            if (!rst_n_in) begin
                cnt_out[k*16+:16] <= 16'(16'h1000 * (k + 1)); // distinct per channel
            end else begin
                cnt_out[k*16+:16] <= cnt_out[k*16+:16] - 16'h1;
            end
        end
    end
endmodule

//--- tb/pwm_capture_top_assertions.sv
/*
  port-level assertions for the capture block.
  assumes strobes never overlap and pins are synchronous.
*/
module pwm_capture_top_assertions #(
    parameter int CNT_W  = 16,
    parameter int GROUPS = 2
) (
    input wire logic                                       REF_CLK_IN,
    input wire logic                                       NRST_IN,
    input wire logic [capture_pkg::ADDR_W-1:0]             ADDR_IN,
    input wire logic [capture_pkg::DATA_W-1:0]             WDATA_IN,
    input wire logic                                       WR_IN,
    input wire logic                                       RD_IN,
    input wire logic [capture_pkg::DATA_W-1:0]             RDATA_OUT,
    input wire logic [GROUPS*capture_pkg::CHANS-1:0]       CAP_PIN_IN,
    input wire logic [GROUPS*capture_pkg::CHANS*CNT_W-1:0] CNT_IN,
    input wire logic [GROUPS-1:0]                          CLR_POL_IN,
    input wire logic [GROUPS-1:0]                          CAP_IRQ_OUT,
    input wire logic                                       IRQ_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    logic [GROUPS*capture_pkg::CHANS-1:0] pin_q;
    // previous pin levels, so a pin change can be blamed for a new flag
    always_ff @(posedge REF_CLK_IN) begin
        pin_q <= CAP_PIN_IN;
    end
    rdata_idle_a: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
        else $error("read data not zero outside read answer");
    ctrl_reserved_a: assert property (RD_IN && ADDR_IN[7:0] == 8'h54
        |=> (RDATA_OUT & 32'hFF20_FF20) == 32'h0)
        else $error("reserved control bits read nonzero");
    unmapped_zero_a: assert property (RD_IN && ADDR_IN[7:0] == 8'hF0
        |=> RDATA_OUT == 32'h0)
        else $error("unmapped offset read nonzero");
    flag_clear_a: assert property (WR_IN && ADDR_IN == 9'h054 && WDATA_IN[4]
        && WDATA_IN[20] && $stable(CAP_PIN_IN[1:0]) && !$past(WR_IN)
        |=> !CAP_IRQ_OUT[0])
        else $error("group a flags not cleared by write of one");
    flag_clear_b_a: assert property (WR_IN && ADDR_IN == 9'h154 && WDATA_IN[4]
        && WDATA_IN[20] && $stable(CAP_PIN_IN[3:2]) && !$past(WR_IN)
        |=> !CAP_IRQ_OUT[1])
        else $error("group b flags not cleared by write of one");
    flag_cause_a: assert property ($rose(CAP_IRQ_OUT[0])
        |-> $past(CAP_PIN_IN != pin_q) || $past(WR_IN, 2))
        else $error("capture flag rose without an input edge");
    irq_cause_a: assert property ($rose(IRQ_OUT)
        |-> $past(CAP_PIN_IN != pin_q) || $past(WR_IN) || $past(WR_IN, 2))
        else $error("interrupt rose without event or mask write");
    status_clear_a: assert property ((RD_IN && ADDR_IN == 9'h068 && !$past(WR_IN)
        && $stable(CAP_PIN_IN)) ##1 (RD_IN && ADDR_IN == 9'h068
        && $stable(CAP_PIN_IN)) |=> RDATA_OUT == 32'h0)
        else $error("status not cleared by read");
endmodule

bind pwm_capture_top pwm_capture_top_assertions #(.CNT_W(CNT_W), .GROUPS(GROUPS)) chk (
    .REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .CAP_PIN_IN(CAP_PIN_IN),
    .CNT_IN(CNT_IN), .CLR_POL_IN(CLR_POL_IN), .CAP_IRQ_OUT(CAP_IRQ_OUT), .IRQ_OUT(IRQ_OUT));

//--- tb/tb_pwm_capture_top.sv
/*
  self-checking bench for the capture block.
  assumes the pin model drives pins and counters; no other stimulus.
*/
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_pwm_capture_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, nrst, wr, rd;
    logic [8:0]  addr;
    logic [31:0] wdata, rdata;
    logic [3:0]  pins, pin_cmd;
    logic [63:0] cnt;
    logic [1:0]  clr_pol, cap_irq;
    logic        irq;
    logic [15:0] rise_val [4];
    int          mismatches, checks_done;
    pwm_capture_top dut (.REF_CLK_IN(ref_clk), .NRST_IN(nrst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CAP_PIN_IN(pins),
        .CNT_IN(cnt), .CLR_POL_IN(clr_pol), .CAP_IRQ_OUT(cap_irq), .IRQ_OUT(irq));
    capture_pins_model pm (.clk_in(ref_clk), .rst_n_in(nrst), .pin_cmd_in(pin_cmd),
        .pin_out(pins), .cnt_out(cnt));
    // bus cycles: one-cycle strobes, read data sampled in the answer cycle only
    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [8:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd <= 1'b1; addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // two reads with no gap; the second answer shows what the first one cleared
    task automatic rd_twice(input logic [8:0] a, output logic [31:0] d0,
                            output logic [31:0] d1);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        #1 d0 = rdata;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d1 = rdata;
    endtask
    // move one pin; e is the counter value in the cycle the edge is seen
    task automatic move_pin(input int k, input logic v, output logic [15:0] e);
        @(posedge ref_clk);
        pin_cmd[k] <= v;
        @(posedge ref_clk);
        #1 e = cnt[k*16+:16];
    endtask
    task automatic t_reset;
        logic [31:0] d;
        rd_reg(9'h054, d); `CHK(d, 32'h0)
        rd_reg(9'h154, d); `CHK(d, 32'h0)
        wr_reg(9'h0F0, 32'hFFFF_FFFF);
        rd_reg(9'h0F0, d); `CHK(d, 32'h0)
        `CHK(irq, 1'b0)
    endtask
    task automatic t_edge(input int g, input int c);
        logic [8:0] b; logic [15:0] e; logic [31:0] d; int k; int sh;
        b = g ? 9'h100 : 9'h000; k = g * 2 + c; sh = c * 16;
        wr_reg(b + 9'h054, 32'h0E << sh);
        move_pin(k, 1'b1, e);
        rd_reg(b + (c ? 9'h060 : 9'h058), d); `CHK(d, {16'h0, e})
        rise_val[k] = e;
        rd_reg(b + 9'h054, d); `CHK(d[sh+:8], 8'h5E)
        `CHK(cap_irq[g], 1'b1)
        wr_reg(b + 9'h054, (32'h1E << sh) | (32'h10 << (16 - sh)));
        `CHK(cap_irq[g], 1'b0)
        rd_reg(b + 9'h054, d); `CHK(d[sh+:8], 8'h0E)
        move_pin(k, 1'b0, e);
        rd_reg(b + (c ? 9'h064 : 9'h05C), d); `CHK(d, {16'h0, e})
        rd_reg(b + 9'h054, d); `CHK(d[sh+:8], 8'h9E)
        wr_reg(b + 9'h054, 32'h8E << sh); // polarity 0: a written one keeps bit 7
        rd_reg(b + 9'h054, d); `CHK(d[sh+:8], 8'h9E)
        @(posedge ref_clk) clr_pol[g] <= 1'b1;
        wr_reg(b + 9'h054, 32'hDE << sh);
        rd_reg(b + 9'h054, d); `CHK(d[sh+:8], 8'h0E)
        @(posedge ref_clk) clr_pol[g] <= 1'b0;
    endtask
    task automatic t_irq(input int g);
        logic [8:0] b; logic [31:0] d; logic [31:0] d2;
        b = g ? 9'h100 : 9'h000;
        `CHK(irq, 1'b0)
        wr_reg(b + 9'h06C, 32'h1);
        `CHK(irq, 1'b1)
        rd_twice(b + 9'h068, d, d2);
        `CHK(d, 32'hF)
        `CHK(irq, 1'b0)
        `CHK(d2, 32'h0)
        wr_reg(b + 9'h06C, 32'h0);
    endtask
    task automatic t_disable_invert;
        logic [15:0] e; logic [31:0] d;
        wr_reg(9'h054, 32'h0006_0000);
        move_pin(1, 1'b1, e);
        rd_reg(9'h060, d); `CHK(d, {16'h0, rise_val[1]})
        rd_reg(9'h054, d); `CHK(d[23:16], 8'h06)
        `CHK(cap_irq[0], 1'b0)
        rd_reg(9'h068, d); `CHK(d, 32'h0)
        // turning the inverter on with the pin high makes a fall, but capture is off
        wr_reg(9'h054, 32'h0007_0000);
        wr_reg(9'h054, 32'h000F_0000);
        move_pin(1, 1'b0, e);
        rd_reg(9'h060, d); `CHK(d, {16'h0, e})
        rd_reg(9'h054, d); `CHK(d[23:16], 8'h5F)
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // watchdog: the tests need under two hundred cycles
    initial begin
        #50000;
        mismatches++;
        final_report;
    end
    // main sequence
    initial begin
        nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 9'h0; wdata = 32'h0;
        pin_cmd = 4'h0; clr_pol = 2'h0; mismatches = 0; checks_done = 0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 2; c++) begin
                t_edge(g, c);
            end
        end
        for (int g = 0; g < 2; g++) begin
            t_irq(g);
        end
        t_disable_invert;
        final_report;
    end
endmodule
